/* ieb_enable_bank.sv */
`timescale 1ns/10ps
`default_nettype none

module ieb_enable_bank #(
    parameter int EN_W = ieb_pkg::EN_WIDTH
) (
    input wire logic hclk, // Bus clock, 250 MHz
    input wire logic hresetn, // Async reset, active low
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size, word only
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready in
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Slave ready
    output logic hresp, // Response, always OKAY
    input wire logic [EN_W-1:0] req_first, // Sources of first register
    input wire logic [EN_W-1:0] req_third, // Sources of third register
    input wire logic [EN_W-1:0] req_fourth, // Sources of fourth register
    output logic [EN_W-1:0] pass_first, // Gated requests to CPU
    output logic [EN_W-1:0] pass_third, // Gated requests to CPU
    output logic [EN_W-1:0] pass_fourth, // Gated requests to CPU
    output logic irq // Level event interrupt
);

    localparam int NR = ieb_pkg::NUM_EN_REGS;
    localparam int AW = ieb_pkg::ADDR_BITS;
    localparam int EW = ieb_pkg::EVT_WIDTH;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // One-hot select of the six registers; used in both phases
    function automatic logic [5:0] decode(input logic [AW-1:0] a);
        logic [5:0] s;
        s = 6'h00;
        unique case (a)
            ieb_pkg::OFS_ENABLE_FIRST: s = 6'h01;
            ieb_pkg::OFS_ENABLE_THIRD: s = 6'h02;
            ieb_pkg::OFS_ENABLE_FOURTH: s = 6'h04;
            ieb_pkg::OFS_EVT_STATUS: s = 6'h08;
            ieb_pkg::OFS_EVT_CLEAR: s = 6'h10;
            ieb_pkg::OFS_EVT_ENABLE: s = 6'h20;
            default: s = 6'h00;
        endcase
        return s;
    endfunction

    function automatic logic [EN_W-1:0] impl_mask(input int idx);
        logic [EN_W-1:0] m;
        m = '0;
        if (idx == ieb_pkg::IDX_FIRST) begin
            m = ieb_pkg::MASK_FIRST[EN_W-1:0];
        end else if (idx == ieb_pkg::IDX_THIRD) begin
            m = ieb_pkg::MASK_THIRD[EN_W-1:0];
        end else begin
            m = ieb_pkg::MASK_FOURTH[EN_W-1:0];
        end
        return m;
    endfunction

    logic [EN_W-1:0] en_r [NR];
    logic [EN_W-1:0] req [NR];
    logic [EN_W-1:0] pass_r [NR];
    logic [NR-1:0] blocked;
    logic [NR-1:0] wr_sel;
    logic [EW-1:0] evt_status_r;
    logic [EW-1:0] evt_enable_r;
    logic [EW-1:0] evt_set;
    logic [EW-1:0] evt_clr;
    logic [5:0] addr_sel;
    logic [5:0] wsel_r;
    logic wpend_r;
    logic take;
    logic wr_now;
    logic reserved_hit;
    logic [31:0] rd_nxt;
    logic [31:0] hrdata_r;

    assign req[ieb_pkg::IDX_FIRST] = req_first;
    assign req[ieb_pkg::IDX_THIRD] = req_third;
    assign req[ieb_pkg::IDX_FOURTH] = req_fourth;

    // ------------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------------
    // Zero wait states: every transfer completes in its first data cycle
    assign hreadyout = 1'b1;
    assign hresp = ieb_pkg::HRESP_OKAY;
    assign hrdata = hrdata_r;

    assign take = hsel && hready && (htrans == ieb_pkg::HTRANS_NONSEQ);
    assign addr_sel = decode(haddr[AW-1:0]);
    assign wr_now = wpend_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wpend_r <= 1'b0;
            wsel_r <= 6'h00;
        end else begin
            wpend_r <= take && hwrite;
            wsel_r <= (take && hwrite) ? addr_sel : 6'h00;
        end
    end

    // Read data is captured in the address phase; a read can never meet
    // a pending write since the master idles during each data phase.
    always_comb begin
        rd_nxt = 32'h0000_0000;
        unique case (1'b1)
            addr_sel[0]: rd_nxt[EN_W-1:0] = en_r[ieb_pkg::IDX_FIRST]; // R7
            addr_sel[1]: rd_nxt[EN_W-1:0] = en_r[ieb_pkg::IDX_THIRD]; // R7
            addr_sel[2]: rd_nxt[EN_W-1:0] = en_r[ieb_pkg::IDX_FOURTH]; // R7
            addr_sel[3]: rd_nxt[EW-1:0] = evt_status_r;
            addr_sel[5]: rd_nxt[EW-1:0] = evt_enable_r;
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            hrdata_r <= rd_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Enable registers and request gating
    // ------------------------------------------------------------------
    assign wr_sel = wsel_r[NR-1:0];

    generate
        for (genvar i = 0; i < NR; i++) begin : g_bank
            // Only implemented positions store; the rest stay zero
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    en_r[i] <= ieb_pkg::RESET_ENABLE[EN_W-1:0]; // R8
                end else if (wr_now && wr_sel[i]) begin
                    en_r[i] <= hwdata[EN_W-1:0] & impl_mask(i); // R8 R7
                end
            end

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    pass_r[i] <= '0;
                end else begin
                    pass_r[i] <= req[i] & en_r[i]; // R1
                end
            end

            assign blocked[i] = |(req[i] & impl_mask(i) & ~en_r[i]);
        end
    endgenerate

    // Named enables of the sources this bank carries
    logic ccu5_event_irq_en;
    logic ccu5_timer_irq_en;
    logic calendar_clock_irq_en;
    logic serial2_collision_irq_en;
    logic serial2_event_irq_en;

    assign ccu5_event_irq_en =
        en_r[ieb_pkg::IDX_FIRST][ieb_pkg::BIT_CCU5_EVENT_IRQ_EN]; // R6
    assign ccu5_timer_irq_en =
        en_r[ieb_pkg::IDX_THIRD][ieb_pkg::BIT_CCU5_TIMER_IRQ_EN]; // R2
    assign calendar_clock_irq_en =
        en_r[ieb_pkg::IDX_FOURTH][ieb_pkg::BIT_CALENDAR_CLOCK_IRQ_EN]; // R3
    assign serial2_collision_irq_en =
        en_r[ieb_pkg::IDX_FOURTH][ieb_pkg::BIT_SERIAL2_COLLISION_IRQ_EN]; // R4
    assign serial2_event_irq_en =
        en_r[ieb_pkg::IDX_FOURTH][ieb_pkg::BIT_SERIAL2_EVENT_IRQ_EN]; // R5

    // Every implemented bit, named or not, is routed to the gated outputs below
    always_comb begin
        pass_first = pass_r[ieb_pkg::IDX_FIRST];
        pass_third = pass_r[ieb_pkg::IDX_THIRD];
        pass_fourth = pass_r[ieb_pkg::IDX_FOURTH];
    end

    // ------------------------------------------------------------------
    // Event status, clear and interrupt
    // ------------------------------------------------------------------
    // A write reaching unimplemented bits of an enable register is flagged so software can
    // spot a driver that assumes more sources than this bank holds.
    assign reserved_hit = wr_now && (
        (wr_sel[ieb_pkg::IDX_FIRST] &&
         |(hwdata[EN_W-1:0] & ~impl_mask(ieb_pkg::IDX_FIRST))) ||
        (wr_sel[ieb_pkg::IDX_THIRD] &&
         |(hwdata[EN_W-1:0] & ~impl_mask(ieb_pkg::IDX_THIRD))) ||
        (wr_sel[ieb_pkg::IDX_FOURTH] &&
         |(hwdata[EN_W-1:0] & ~impl_mask(ieb_pkg::IDX_FOURTH))));

    always_comb begin
        evt_set = '0;
        evt_set[ieb_pkg::EVT_BLOCKED_FIRST] = blocked[ieb_pkg::IDX_FIRST];
        evt_set[ieb_pkg::EVT_BLOCKED_THIRD] = blocked[ieb_pkg::IDX_THIRD];
        evt_set[ieb_pkg::EVT_BLOCKED_FOURTH] = blocked[ieb_pkg::IDX_FOURTH];
        evt_set[ieb_pkg::EVT_RESERVED_WRITE] = reserved_hit;
    end

    assign evt_clr = (wr_now && wsel_r[4]) ? hwdata[EW-1:0] : '0;

    // Set wins over clear so an event in the clearing cycle survives
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            evt_status_r <= ieb_pkg::RESET_EVT;
        end else begin
            evt_status_r <= (evt_status_r & ~evt_clr) | evt_set;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            evt_enable_r <= ieb_pkg::RESET_EVT;
        end else if (wr_now && wsel_r[5]) begin
            evt_enable_r <= hwdata[EW-1:0];
        end
    end

    assign irq = |(evt_status_r & evt_enable_r);

endmodule // ieb_enable_bank

`default_nettype wire

/* ieb_enable_bank_bench.sv */
`timescale 1ns/10ps
`default_nettype none

module ieb_enable_bank_bench;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd_v;
    logic hreadyout, hresp, irq;
    logic [15:0] req [3] = '{default: 16'h0};
    logic [15:0] pass [3];
    logic [7:0] ofs [3] = '{8'h00, 8'h04, 8'h08};
    logic [15:0] msk [3] = '{ieb_pkg::MASK_FIRST, 16'h0200, 16'h4006};
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;

    always #2 hclk = ~hclk;

    ieb_enable_bank i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .req_first(req[0]),
        .req_third(req[1]), .req_fourth(req[2]), .pass_first(pass[0]),
        .pass_third(pass[1]), .pass_fourth(pass[2]), .irq(irq));

    // ------------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask

    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= ieb_pkg::HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_v = hrdata;
        chk("response", 32'h0, {31'h0, hresp});
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                        input string nm);
        xfer(a, 1'b0, 32'h0);
        chk(nm, e, rd_v);
    endtask

    task automatic end_sim;
        $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Whole run needs under a hundred cycles
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            end_sim();
        end
    end

    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            rchk(ofs[i], 32'h0, "enable reset");
            chk("pass reset", 32'h0, {16'h0, pass[i]});
        end
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            xfer(ofs[i], 1'b1, 32'hffffffff);
            rchk(ofs[i], {16'h0, msk[i]}, "enable mask");
            req[i] <= 16'hffff;
            repeat (2) @(posedge hclk);
            chk("pass on", {16'h0, msk[i]}, {16'h0, pass[i]});
            xfer(ofs[i], 1'b1, 32'h0);
            repeat (2) @(posedge hclk);
            chk("pass off", 32'h0, {16'h0, pass[i]});
            req[i] <= 16'h0;
        end
        $display("test gating done");
        xfer(8'h04, 1'b1, 32'h0000fdff);
        rchk(8'h04, 32'h0, "third unimplemented");
        rchk(8'h40, 32'h0, "unmapped");
        $display("test unimplemented done");
        xfer(ieb_pkg::OFS_EVT_CLEAR, 1'b1, 32'hf);
        req[0] <= 16'h0040;
        @(posedge hclk);
        req[0] <= 16'h0;
        repeat (2) @(posedge hclk);
        rchk(ieb_pkg::OFS_EVT_STATUS, 32'h1, "status");
        chk("irq masked", 32'h0, {31'h0, irq});
        xfer(ieb_pkg::OFS_EVT_ENABLE, 1'b1, 32'h1);
        @(posedge hclk);
        chk("irq raised", 32'h1, {31'h0, irq});
        xfer(ieb_pkg::OFS_EVT_CLEAR, 1'b1, 32'h1);
        @(posedge hclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        $display("test interrupt done");
        end_sim();
    end
endmodule // ieb_enable_bank_bench

`default_nettype wire

/* ieb_enable_bank_checker.sv */
`timescale 1ns/10ps
`default_nettype none

module ieb_enable_bank_checker #(
    parameter int EN_W = 16
) (
    input wire logic hclk, // Bus clock
    input wire logic hresetn, // Async reset, active low
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready in
    input wire logic [31:0] hrdata, // Read data
    input wire logic hreadyout, // Slave ready
    input wire logic hresp, // Response
    input wire logic [EN_W-1:0] req_first, // Sources, first
    input wire logic [EN_W-1:0] req_third, // Sources, third
    input wire logic [EN_W-1:0] req_fourth, // Sources, fourth
    input wire logic [EN_W-1:0] pass_first, // Gated, first
    input wire logic [EN_W-1:0] pass_third, // Gated, third
    input wire logic [EN_W-1:0] pass_fourth, // Gated, fourth
    input wire logic irq // Event interrupt
);
    // ------------------------------------------------------------------
    // Shadow of the enable registers, rebuilt from bus writes
    // ------------------------------------------------------------------
    logic wr_q;
    logic [7:0] a_q;
    logic [15:0] sh_f, sh_t, sh_o;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            a_q <= 8'h00;
        end else if (hready) begin
            wr_q <= hsel && htrans == ieb_pkg::HTRANS_NONSEQ && hwrite;
            a_q <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sh_f <= 16'h0000;
            sh_t <= 16'h0000;
            sh_o <= 16'h0000;
        end else if (wr_q && hready) begin
            if (a_q == ieb_pkg::OFS_ENABLE_FIRST)
                sh_f <= hwdata[15:0] & ieb_pkg::MASK_FIRST;
            if (a_q == ieb_pkg::OFS_ENABLE_THIRD)
                sh_t <= hwdata[15:0] & ieb_pkg::MASK_THIRD;
            if (a_q == ieb_pkg::OFS_ENABLE_FOURTH)
                sh_o <= hwdata[15:0] & ieb_pkg::MASK_FOURTH;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_rd(logic [7:0] a);
        hsel && hready && htrans == ieb_pkg::HTRANS_NONSEQ && !hwrite
            && haddr[7:0] == a;
    endsequence

    AST_PASS_FIRST: assert property (
        pass_first == $past(req_first & sh_f)) else $error("first gating wrong");
    AST_PASS_THIRD: assert property (
        pass_third == $past(req_third & sh_t)) else $error("third gating wrong");
    AST_PASS_FOURTH: assert property (
        pass_fourth == $past(req_fourth & sh_o)) else $error("fourth gating wrong");
    AST_RD_FIRST: assert property (
        s_rd(ieb_pkg::OFS_ENABLE_FIRST) |=> hrdata == {16'h0000, sh_f})
        else $error("first enable readback wrong");
    AST_RD_THIRD: assert property (
        s_rd(ieb_pkg::OFS_ENABLE_THIRD) |=> hrdata == {16'h0000, sh_t})
        else $error("third enable readback wrong");
    AST_RD_FOURTH: assert property (
        s_rd(ieb_pkg::OFS_ENABLE_FOURTH) |=> hrdata == {16'h0000, sh_o})
        else $error("fourth enable readback wrong");
    AST_RD_UPPER: assert property (
        hsel && hready && htrans == ieb_pkg::HTRANS_NONSEQ && !hwrite
        |=> hrdata[31:16] == 16'h0000) else $error("upper read bits set");
    AST_RESET_CLEAR: assert property (
        $rose(hresetn) |-> (pass_first | pass_third | pass_fourth) == '0)
        else $error("gated requests set after reset");
endmodule // ieb_enable_bank_checker

bind ieb_enable_bank ieb_enable_bank_checker #(.EN_W(EN_W)) i_chk (.*);

`default_nettype wire

/* ieb_pkg.sv */
// Behaviour
// (R1) Each implemented enable bit passes its source request when one, blocks when zero.
// (R2) Third enable register bit 9 enables the timer interrupt of capture unit 5.
// (R3) Fourth enable register bit 14 enables the real-time clock interrupt.
// (R4) Fourth enable register bit 2 enables second serial port bus collision.
// (R5) Fourth enable register bit 1 enables second serial port event interrupt.
// (R6) First enable register bit 6 enables the event interrupt of capture unit 5.
// (R7) Unimplemented positions of the third and fourth registers read as zero.
// (R8) Implemented bits are read/write, zero at reset; other bit writes ignored.
`default_nettype none

package ieb_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_ENABLE_FIRST = 8'h00;
    localparam logic [7:0] OFS_ENABLE_THIRD = 8'h04;
    localparam logic [7:0] OFS_ENABLE_FOURTH = 8'h08;
    localparam logic [7:0] OFS_EVT_STATUS = 8'h0c;
    localparam logic [7:0] OFS_EVT_CLEAR = 8'h10;
    localparam logic [7:0] OFS_EVT_ENABLE = 8'h14;

    localparam int ADDR_BITS = 8;
    localparam int EN_WIDTH = 16;
    localparam int NUM_EN_REGS = 3;

    // Index of each enable register in the bank
    localparam int IDX_FIRST = 0;
    localparam int IDX_THIRD = 1;
    localparam int IDX_FOURTH = 2;

    // ------------------------------------------------------------------
    // Enable bit positions
    // ------------------------------------------------------------------
    localparam int BIT_CCU5_EVENT_IRQ_EN = 6;
    localparam int BIT_CCU5_TIMER_IRQ_EN = 9;
    localparam int BIT_CALENDAR_CLOCK_IRQ_EN = 14;
    localparam int BIT_SERIAL2_COLLISION_IRQ_EN = 2;
    localparam int BIT_SERIAL2_EVENT_IRQ_EN = 1;

    // Implemented positions of each enable register
    localparam logic [15:0] MASK_FIRST = 16'hf85f;
    localparam logic [15:0] MASK_THIRD =
        16'h0001 << BIT_CCU5_TIMER_IRQ_EN;
    localparam logic [15:0] MASK_FOURTH =
        (16'h0001 << BIT_CALENDAR_CLOCK_IRQ_EN) |
        (16'h0001 << BIT_SERIAL2_COLLISION_IRQ_EN) |
        (16'h0001 << BIT_SERIAL2_EVENT_IRQ_EN);

    localparam logic [15:0] RESET_ENABLE = 16'h0000;

    // ------------------------------------------------------------------
    // Event status layout
    // ------------------------------------------------------------------
    localparam int EVT_WIDTH = 4;
    localparam int EVT_BLOCKED_FIRST = 0;
    localparam int EVT_BLOCKED_THIRD = 1;
    localparam int EVT_BLOCKED_FOURTH = 2;
    localparam int EVT_RESERVED_WRITE = 3;
    localparam logic [3:0] RESET_EVT = 4'h0;

    // AHB constants
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

endpackage

`default_nettype wire
